// ### rtl/scm_cfg.svh
// register offsets, codes, reset values and limits of the sample clock mode control
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH
// How it works
// RULE_01: a master card distributes its sample clock to at most eight cards.
// RULE_02: the distributed clock comes from the first oscillator or the external reference.
// RULE_03: source code 1 selects the internal programmable oscillator feeding the PLL.
// RULE_04: a sample rate write takes hertz; the block derives divider settings itself.
// RULE_05: reading the sample rate returns the achievable rate that the request was resolved to.
// RULE_06: clock output enable 1 drives the clock pin, 0 leaves it high impedance.
// RULE_07: a read-only register reports the frequency at the clock output.
// RULE_08: the clock output works with every clock source.
// RULE_09: standard mode rates are the maximum divided by two to the 0..17.
// RULE_10: standard mode rounds a rate between steps up to the next step.
// RULE_11: after reset standard mode is active and fine granularity is off.
// RULE_12: standard mode keeps the converter at maximum clock and drops samples.
// RULE_13: software enables fine granularity before writing the rate.
// RULE_14: fine granularity mode takes rates in 1 Hz steps straight from the PLL.
// RULE_15: fine granularity mode never produces a rate inside the forbidden gap.
// RULE_16: the converter clock always comes from a PLL locked to a known reference.
// RULE_17: while star synchronization is active only standard mode is used.
// RULE_18: a read-only register shows a bitmask of supported clock sources.
// RULE_19: source code 4 selects the optional second oscillator as PLL reference.
// RULE_20: a read/write register enables fine granularity, disabled after reset.
// RULE_21: reading the source register returns the active source code.
`define SCM_ADDR_W 20
`define SCM_OFS_SAMPLE_RATE 20'h04e20
`define SCM_OFS_CLKOUT_EN 20'h04e8e
`define SCM_OFS_CLKOUT_FREQ 20'h04e8f
`define SCM_OFS_CLK_SRC 20'h04ee8
`define SCM_OFS_SUPPORTED 20'h04ee9
`define SCM_OFS_FINE_EN 20'h480bc
`define SCM_SRC_INTERNAL 32'h00000001
`define SCM_SRC_SECOND_OSC 32'h00000004
`define SCM_SRC_EXT_REF 32'h00000020
`define SCM_SRC_BACKPLANE 32'h00000040
`define SCM_SUPPORTED_DEF 32'h00000025
`define SCM_RST_CLK_SRC 32'h00000001
`define SCM_MAX_SHIFT 5'h11
`define SCM_MAX_SYNC_CARDS 4'h8
`define SCM_MAX_RATE_DEF 64'h000000000ee6b280
`define SCM_GAP_LO_DEF 64'h0000000005f5e100
`define SCM_GAP_HI_DEF 64'h00000000068e7780
`endif

// ### rtl/scm_pkg.sv
// shared types of the sample clock mode control
package scm_pkg;
   typedef logic [63:0] scm_rate_t;
   typedef enum logic {scm_idle, scm_search} scm_calc_state_t;
endpackage : scm_pkg

// ### rtl/scm_rate_if.sv
// request and answer between register logic and rate calculator
`timescale 1ns/1ns
interface scm_rate_if;
   logic start;
   logic special;
   scm_pkg::scm_rate_t req;
   logic busy;
   logic done;
   scm_pkg::scm_rate_t rate;
   logic [4:0] shift;
   modport ctrl (output start, special, req, input busy, done, rate, shift);
   modport calc (input start, special, req, output busy, done, rate, shift);
endinterface : scm_rate_if

// ### rtl/scm_rate_calc.sv
// turns a requested rate into the achievable rate and decimation shift
`timescale 1ns/1ns
`include "scm_cfg.svh"
module scm_rate_calc #(
   parameter logic [63:0] MAX_RATE = `SCM_MAX_RATE_DEF,
   parameter logic [63:0] GAP_LO = `SCM_GAP_LO_DEF,
   parameter logic [63:0] GAP_HI = `SCM_GAP_HI_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   scm_rate_if.calc rif
);
   localparam logic [63:0] MIN_RATE = MAX_RATE >> `SCM_MAX_SHIFT;
   scm_pkg::scm_calc_state_t state;
   scm_pkg::scm_rate_t req_q;
   scm_pkg::scm_rate_t cand;
   logic [4:0] k;

   // fine mode: clamp to range, lift out of the gap to its upper edge
   function automatic scm_pkg::scm_rate_t fine_rate(input scm_pkg::scm_rate_t r);
      scm_pkg::scm_rate_t v;
      v = r;
      if (v > MAX_RATE) v = MAX_RATE;
      if (v < MIN_RATE) v = MIN_RATE;
      if (v > GAP_LO && v < GAP_HI) v = GAP_HI; // RULE_15
      return v;
   endfunction : fine_rate

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= scm_pkg::scm_idle;
         rif.done <= 1'b0;
         rif.busy <= 1'b0;
         rif.rate <= MAX_RATE;
         rif.shift <= 5'h00;
         req_q <= 64'h0;
         cand <= 64'h0;
         k <= 5'h00;
      end else begin
         rif.done <= 1'b0;
         unique case (state)
            scm_pkg::scm_idle: begin
               if (rif.start && rif.special) begin
                  rif.rate <= fine_rate(rif.req); // RULE_14
                  rif.shift <= 5'h00;
                  rif.done <= 1'b1;
               end else if (rif.start) begin
                  req_q <= rif.req;
                  cand <= MAX_RATE;
                  k <= 5'h00;
                  rif.busy <= 1'b1;
                  state <= scm_pkg::scm_search;
               end
            end
            scm_pkg::scm_search: begin
               // halve while the next step still meets the request: rounds up
               if (k < `SCM_MAX_SHIFT && (cand >> 1) >= req_q) begin // RULE_10
                  cand <= cand >> 1;
                  k <= k + 5'h01; // RULE_09
               end else begin
                  rif.rate <= cand;
                  rif.shift <= k;
                  rif.done <= 1'b1;
                  rif.busy <= 1'b0;
                  state <= scm_pkg::scm_idle;
               end
            end
         endcase
      end
   end
endmodule : scm_rate_calc

// ### rtl/scm_drop.sv
// keeps one converter sample in two to the shift, drops the rest
`timescale 1ns/1ns
module scm_drop #(
   parameter int CNT_W = 17
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic tick,
   input wire logic [4:0] shift,
   output logic keep
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] mask;

   assign mask = CNT_W'((18'h00001 << shift) - 18'h00001);
   assign keep = run && tick && ((cnt & mask) == '0); // RULE_12

   always_ff @(posedge mclk) begin
      if (!rst_n || !run) begin
         cnt <= '0;
      end else if (tick) begin
         cnt <= cnt + CNT_W'(1);
      end
   end
endmodule : scm_drop

// ### rtl/scm_top.sv
// sample clock mode control: registers, mode logic, clock output and sync fan-out
`timescale 1ns/1ns
`include "scm_cfg.svh"
module scm_top #(
   parameter logic [63:0] MAX_RATE = `SCM_MAX_RATE_DEF,
   parameter logic [63:0] GAP_LO = `SCM_GAP_LO_DEF,
   parameter logic [63:0] GAP_HI = `SCM_GAP_HI_DEF,
   parameter logic [31:0] SUPPORTED = `SCM_SUPPORTED_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`SCM_ADDR_W-1:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   output logic [63:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_busy,
   input wire logic adc_tick_pin,
   input wire logic pll_lock_pin,
   input wire logic star_sync_pin,
   input wire logic [3:0] sync_card_count,
   output logic [31:0] pll_ref_sel,
   output logic [63:0] pll_rate,
   output logic [4:0] drop_shift,
   output logic sample_keep,
   output logic clk_out,
   output logic clk_out_oe_n,
   output logic sync_clk_out,
   output logic sync_clk_oe_n
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic tick_m;
   logic tick_s;
   logic tick_d;
   logic lock_m;
   logic lock_s;
   logic star_m;
   logic star_s;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tick_m <= 1'b0;
         tick_s <= 1'b0;
         tick_d <= 1'b0;
         lock_m <= 1'b0;
         lock_s <= 1'b0;
         star_m <= 1'b0;
         star_s <= 1'b0;
      end else begin
         tick_m <= adc_tick_pin;
         tick_s <= tick_m;
         tick_d <= tick_s;
         lock_m <= pll_lock_pin;
         lock_s <= lock_m;
         star_m <= star_sync_pin;
         star_s <= star_m;
      end
   end

   logic tick_rise;
   assign tick_rise = tick_s && !tick_d;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   logic clk_src_is_legal;
   logic wr_rate;
   logic wr_clkout;
   logic wr_src;
   logic wr_fine;

   // a legal source code is a single bit that the card supports
   assign clk_src_is_legal = (reg_wdata[31:0] != 32'h0)
      && ((reg_wdata[31:0] & (reg_wdata[31:0] - 32'h1)) == 32'h0)
      && ((reg_wdata[31:0] & SUPPORTED) != 32'h0);
   assign wr_rate = reg_wr && (reg_addr == `SCM_OFS_SAMPLE_RATE);
   assign wr_clkout = reg_wr && (reg_addr == `SCM_OFS_CLKOUT_EN);
   assign wr_src = reg_wr && (reg_addr == `SCM_OFS_CLK_SRC);
   assign wr_fine = reg_wr && (reg_addr == `SCM_OFS_FINE_EN);

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [31:0] clk_src;
   logic clkout_en;
   logic fine_en;
   logic mode_fine;
   scm_pkg::scm_rate_t achieved_rate;
   logic [4:0] achieved_shift;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clk_src <= `SCM_RST_CLK_SRC;
      end else if (wr_src && clk_src_is_legal) begin
         clk_src <= reg_wdata[31:0]; // RULE_03 RULE_19
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clkout_en <= 1'b0;
      end else if (wr_clkout) begin
         clkout_en <= reg_wdata[0]; // RULE_06 RULE_08
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fine_en <= 1'b0; // RULE_11
      end else if (wr_fine) begin
         fine_en <= reg_wdata[0]; // RULE_20
      end
   end

   // ------------------------------------------------------------
   // rate calculation
   // ------------------------------------------------------------
   scm_rate_if rif ();

   scm_rate_calc #(
      .MAX_RATE(MAX_RATE),
      .GAP_LO(GAP_LO),
      .GAP_HI(GAP_HI)
   ) u_calc (
      .mclk(mclk),
      .rst_n(rst_n),
      .rif(rif)
   );

   // the mode is sampled at the rate write: enabling fine mode later does not
   // touch a rate already set, and star sync forces the standard path
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rif.start <= 1'b0;
         rif.special <= 1'b0;
         rif.req <= 64'h0;
      end else begin
         rif.start <= wr_rate && !reg_busy; // RULE_04
         if (wr_rate && !reg_busy) begin
            rif.req <= reg_wdata;
            rif.special <= fine_en && !star_s; // RULE_13 RULE_17
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_busy <= 1'b0;
      end else begin
         reg_busy <= (wr_rate && !reg_busy) || rif.start || rif.busy;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         achieved_rate <= MAX_RATE;
         achieved_shift <= 5'h00;
         mode_fine <= 1'b0;
      end else if (star_s) begin
         mode_fine <= 1'b0; // RULE_17
         if (rif.done) begin
            achieved_rate <= rif.special ? MAX_RATE : rif.rate;
            achieved_shift <= rif.shift;
         end
      end else if (rif.done) begin
         achieved_rate <= rif.rate; // RULE_05
         achieved_shift <= rif.shift;
         mode_fine <= rif.special;
      end
   end

   // ------------------------------------------------------------
   // converter clock and sample dropping
   // ------------------------------------------------------------
   logic keep_c;

   scm_drop #(
      .CNT_W(17)
   ) u_drop (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(lock_s),
      .tick(tick_rise),
      .shift(achieved_shift),
      .keep(keep_c)
   );

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pll_ref_sel <= `SCM_RST_CLK_SRC;
         pll_rate <= MAX_RATE;
         drop_shift <= 5'h00;
         sample_keep <= 1'b0;
      end else begin
         pll_ref_sel <= clk_src; // RULE_16
         pll_rate <= mode_fine ? achieved_rate : MAX_RATE; // RULE_12 RULE_14
         drop_shift <= mode_fine ? 5'h00 : achieved_shift;
         sample_keep <= keep_c; // RULE_16
      end
   end

   // ------------------------------------------------------------
   // clock output and star distribution
   // ------------------------------------------------------------
   logic div_clk;
   logic sync_ok;

   // only the first oscillator or the external reference may feed the star,
   // and the fan-out is limited to the documented card count
   assign sync_ok = star_s && (sync_card_count <= `SCM_MAX_SYNC_CARDS)
      && ((clk_src == `SCM_SRC_INTERNAL) || (clk_src == `SCM_SRC_EXT_REF)); // RULE_01 RULE_02

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_clk <= 1'b0;
      end else if (keep_c) begin
         div_clk <= !div_clk;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clk_out <= 1'b0;
         clk_out_oe_n <= 1'b1;
         sync_clk_out <= 1'b0;
         sync_clk_oe_n <= 1'b1;
      end else begin
         clk_out <= clkout_en && div_clk; // RULE_08
         clk_out_oe_n <= !clkout_en; // RULE_06
         sync_clk_out <= sync_ok && div_clk;
         sync_clk_oe_n <= !sync_ok; // RULE_01
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [63:0] next_rdata;

   always_comb begin
      next_rdata = 64'h0;
      unique case (reg_addr)
         `SCM_OFS_SAMPLE_RATE: next_rdata = achieved_rate; // RULE_05
         `SCM_OFS_CLKOUT_EN: next_rdata = {63'h0, clkout_en};
         `SCM_OFS_CLKOUT_FREQ: next_rdata = clkout_en ? {32'h0, achieved_rate[31:0]} : 64'h0; // RULE_07
         `SCM_OFS_CLK_SRC: next_rdata = {32'h0, clk_src}; // RULE_21
         `SCM_OFS_SUPPORTED: next_rdata = {32'h0, SUPPORTED}; // RULE_18
         `SCM_OFS_FINE_EN: next_rdata = {63'h0, fine_en};
         default: next_rdata = 64'h0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 64'h0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_busy_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rif.busy) |-> ##[1:19] !rif.busy) // RULE_04
      else $error("rate search did not finish in time");

   a_std_power: assert property (@(posedge mclk) disable iff (!rst_n)
      rif.done && !rif.special |-> rif.rate == (MAX_RATE >> rif.shift)
         && rif.shift <= 5'h11) // RULE_09
      else $error("standard rate is not a power-of-two division");

   a_std_round_up: assert property (@(posedge mclk) disable iff (!rst_n)
      rif.done && !rif.special && rif.shift != 5'h00 |-> rif.rate >= rif.req) // RULE_10
      else $error("standard rate rounded below the request");

   a_gap_avoid: assert property (@(posedge mclk) disable iff (!rst_n)
      rif.done && rif.special |-> !(rif.rate > GAP_LO && rif.rate < GAP_HI)) // RULE_15
      else $error("fine rate inside the forbidden gap");

   a_rate_readback: assert property (@(posedge mclk) disable iff (!rst_n)
      rif.done && !star_s ##[1:6] reg_rd && !reg_busy && reg_addr == `SCM_OFS_SAMPLE_RATE
         |=> reg_rvalid && reg_rdata == rif.rate) // RULE_05
      else $error("sample rate read does not show achieved rate");

   a_std_pll: assert property (@(posedge mclk) disable iff (!rst_n)
      !mode_fine ##1 !mode_fine |-> pll_rate == MAX_RATE) // RULE_12
      else $error("converter clock left maximum in standard mode");

   a_clkout_tri: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_clkout && !reg_wdata[0] |=> ##1 clk_out_oe_n && !clk_out) // RULE_06
      else $error("clock output not released after disable");

   a_fine_reset: assert property (@(posedge mclk)
      !rst_n |=> !fine_en && !mode_fine) // RULE_11
      else $error("fine mode active after reset");

   a_star_std: assert property (@(posedge mclk) disable iff (!rst_n)
      star_s |=> !mode_fine) // RULE_17
      else $error("fine mode while star sync active");

   a_src_read: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == `SCM_OFS_CLK_SRC |=> reg_rdata[31:0] == $past(clk_src)) // RULE_21
      else $error("source read does not show active source");

   a_keep_locked: assert property (@(posedge mclk) disable iff (!rst_n)
      sample_keep |-> $past(lock_s)) // RULE_16
      else $error("sample kept without locked PLL");

   c_std_search: cover property (@(posedge mclk) disable iff (!rst_n)
      rif.done && !rif.special && rif.shift == 5'h11);
   c_fine_rate: cover property (@(posedge mclk) disable iff (!rst_n)
      rif.done && rif.special);
   c_clkout_on: cover property (@(posedge mclk) disable iff (!rst_n)
      !clk_out_oe_n && clk_out);
   c_star_drive: cover property (@(posedge mclk) disable iff (!rst_n)
      !sync_clk_oe_n);
endmodule : scm_top

// ### testbench/sample_clock_mode_control_tb.sv
// self-checking bench of the sample clock mode control
`timescale 1ns/1ns
`include "scm_cfg.svh"
module sample_clock_mode_control_tb;
   // --------------------------------------------
   // stimulus, outputs and bookkeeping
   // --------------------------------------------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [`SCM_ADDR_W-1:0] reg_addr = '0;
   logic [63:0] reg_wdata = '0;
   logic adc_tick_pin = 1'b0;
   logic pll_lock_pin = 1'b0;
   logic star_sync_pin = 1'b0;
   logic [3:0] sync_card_count = 4'h0;
   logic [63:0] reg_rdata;
   logic reg_rvalid;
   logic reg_busy;
   logic [31:0] pll_ref_sel;
   logic [63:0] pll_rate;
   logic [4:0] drop_shift;
   logic sample_keep;
   logic clk_out;
   logic clk_out_oe_n;
   logic sync_clk_out;
   logic sync_clk_oe_n;
   int err_count = 0;
   int comparisons = 0;
   int keeps = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h33124069;
   logic [63:0] exp_q[$];
   logic [63:0] std_tab[6] = '{64'h3b9aca0, 64'hbebc200, 64'h11e1a300, 64'h1, 64'h774,
      64'hee6b280};
   logic [63:0] fine_tab[6] = '{64'h75bcd15, 64'h6422c40, 64'h5f5e100, 64'h68e7780, 64'h1,
      64'h11e1a300};

   always #25 mclk = ~mclk;

   scm_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_busy(reg_busy), .adc_tick_pin(adc_tick_pin),
      .pll_lock_pin(pll_lock_pin), .star_sync_pin(star_sync_pin),
      .sync_card_count(sync_card_count), .pll_ref_sel(pll_ref_sel), .pll_rate(pll_rate),
      .drop_shift(drop_shift), .sample_keep(sample_keep), .clk_out(clk_out),
      .clk_out_oe_n(clk_out_oe_n), .sync_clk_out(sync_clk_out),
      .sync_clk_oe_n(sync_clk_oe_n));

   // --------------------------------------------
   // expectations and comparisons
   // --------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // smallest divided step that is not below the request
   function automatic logic [4:0] std_shift(input logic [63:0] r);
      for (int k = 17; k >= 0; k--) begin
         if ((`SCM_MAX_RATE_DEF >> k) >= r) return 5'(k);
      end
      return 5'h00;
   endfunction : std_shift

   function automatic logic [63:0] fine_rate(input logic [63:0] r);
      if (r < (`SCM_MAX_RATE_DEF >> 17)) return `SCM_MAX_RATE_DEF >> 17;
      if (r > `SCM_MAX_RATE_DEF) return `SCM_MAX_RATE_DEF;
      if (r > `SCM_GAP_LO_DEF && r < `SCM_GAP_HI_DEF) return `SCM_GAP_HI_DEF;
      return r;
   endfunction : fine_rate

   task automatic chk_pin(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_pin

   task automatic chk_read(input logic [63:0] exp, input logic [63:0] got);
      chk_pin("register read", exp, got);
   endtask : chk_read

   task automatic tally_and_finish();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // read results are paired with the oldest note in the queue
   always @(negedge mclk) begin
      if (sample_keep === 1'b1) keeps++;
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() > 0) begin
            chk_read(exp_q.pop_front(), reg_rdata);
         end else begin
            err_count++;
            $display("wrong value read strobe expected none seen %h", reg_rdata);
         end
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // --------------------------------------------
   // register port tasks
   // --------------------------------------------
   task automatic wr(input logic [19:0] a, input logic [63:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [63:0] e);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      exp_q.push_back(e);
      @(negedge mclk);
      reg_rd = 1'b0;
   endtask : rd

   // bounded wait for the rate result, then let the outputs follow
   task automatic settle();
      int n;
      n = 0;
      while (reg_busy !== 1'b0 && n < 60) begin
         @(negedge mclk);
         n++;
      end
      chk_pin("busy released", 64'h0, 64'(reg_busy));
      repeat (3) @(negedge mclk);
   endtask : settle

   task automatic std_req(input logic [63:0] r);
      logic [4:0] s;
      s = std_shift(r);
      wr(`SCM_OFS_SAMPLE_RATE, r);
      settle();
      rd(`SCM_OFS_SAMPLE_RATE, `SCM_MAX_RATE_DEF >> s);
      chk_pin("drop shift", 64'(s), 64'(drop_shift));
      chk_pin("converter rate", `SCM_MAX_RATE_DEF, pll_rate);
   endtask : std_req

   task automatic fine_req(input logic [63:0] r, input logic [63:0] e);
      wr(`SCM_OFS_SAMPLE_RATE, r);
      settle();
      rd(`SCM_OFS_SAMPLE_RATE, e);
      chk_pin("drop shift", 64'h0, 64'(drop_shift));
      chk_pin("converter rate", e, pll_rate);
   endtask : fine_req

   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge mclk);
         adc_tick_pin = 1'b1;
         repeat (2) @(negedge mclk);
         adc_tick_pin = 1'b0;
         repeat (2) @(negedge mclk);
      end
      repeat (8) @(negedge mclk);
   endtask : ticks

   // --------------------------------------------
   // main sequence
   // --------------------------------------------
   initial begin
      logic [63:0] r;
      logic [31:0] sh;
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      chk_pin("clock out enable", 64'h1, 64'(clk_out_oe_n));
      chk_pin("reference select", 64'h1, 64'(pll_ref_sel));
      rd(`SCM_OFS_CLK_SRC, 64'h1);
      rd(`SCM_OFS_SAMPLE_RATE, `SCM_MAX_RATE_DEF);
      rd(`SCM_OFS_FINE_EN, 64'h0);
      rd(`SCM_OFS_SUPPORTED, 64'h25);
      rd(`SCM_OFS_CLKOUT_FREQ, 64'h0);
      rd(20'h00001, 64'h0);
      wr(`SCM_OFS_CLKOUT_FREQ, 64'h5);
      rd(`SCM_OFS_CLKOUT_FREQ, 64'h0);
      foreach (std_tab[i]) std_req(std_tab[i]);
      repeat (8) begin
         sh = xs();
         r = {32'h0, xs()} >> sh[4:0];
         std_req(r);
      end
      // a second rate write while busy is dropped
      wr(`SCM_OFS_SAMPLE_RATE, 64'h3b9aca0);
      wr(`SCM_OFS_SAMPLE_RATE, 64'h3e8);
      settle();
      rd(`SCM_OFS_SAMPLE_RATE, 64'h3b9aca0);
      // enabling fine mode after the rate write leaves the rate as resolved
      wr(`SCM_OFS_SAMPLE_RATE, 64'h75bcd15);
      settle();
      wr(`SCM_OFS_FINE_EN, 64'h1);
      rd(`SCM_OFS_SAMPLE_RATE, 64'h7735940);
      rd(`SCM_OFS_FINE_EN, 64'h1);
      foreach (fine_tab[i]) fine_req(fine_tab[i], fine_rate(fine_tab[i]));
      wr(`SCM_OFS_CLK_SRC, 64'h4);
      wr(`SCM_OFS_CLK_SRC, 64'h3);
      wr(`SCM_OFS_CLK_SRC, 64'h40);
      rd(`SCM_OFS_CLK_SRC, 64'h4);
      chk_pin("reference select", 64'h4, 64'(pll_ref_sel));
      wr(`SCM_OFS_CLKOUT_EN, 64'h1);
      repeat (3) @(negedge mclk);
      chk_pin("clock out enable", 64'h0, 64'(clk_out_oe_n));
      rd(`SCM_OFS_CLKOUT_EN, 64'h1);
      rd(`SCM_OFS_CLKOUT_FREQ, `SCM_MAX_RATE_DEF & 64'h00000000ffffffff);
      wr(`SCM_OFS_CLK_SRC, 64'h1);
      rd(`SCM_OFS_CLK_SRC, 64'h1);
      wr(`SCM_OFS_CLKOUT_EN, 64'h0);
      repeat (3) @(negedge mclk);
      chk_pin("clock out enable", 64'h1, 64'(clk_out_oe_n));
      chk_pin("clock out data", 64'h0, 64'(clk_out));
      rd(`SCM_OFS_CLKOUT_FREQ, 64'h0);
      // one converter sample in four is kept, none without lock
      wr(`SCM_OFS_FINE_EN, 64'h0);
      std_req(64'h3b9aca0);
      pll_lock_pin = 1'b1;
      repeat (4) @(negedge mclk);
      keeps = 0;
      ticks(16);
      chk_pin("kept samples", 64'h4, 64'(keeps));
      pll_lock_pin = 1'b0;
      repeat (4) @(negedge mclk);
      keeps = 0;
      ticks(8);
      chk_pin("kept samples", 64'h0, 64'(keeps));
      star_sync_pin = 1'b1;
      sync_card_count = 4'h8;
      repeat (6) @(negedge mclk);
      chk_pin("star clock enable", 64'h0, 64'(sync_clk_oe_n));
      sync_card_count = 4'h9;
      repeat (4) @(negedge mclk);
      chk_pin("star clock enable", 64'h1, 64'(sync_clk_oe_n));
      chk_pin("star clock data", 64'h0, 64'(sync_clk_out));
      sync_card_count = 4'h8;
      wr(`SCM_OFS_CLK_SRC, 64'h20);
      repeat (4) @(negedge mclk);
      chk_pin("star clock enable", 64'h0, 64'(sync_clk_oe_n));
      wr(`SCM_OFS_CLK_SRC, 64'h4);
      repeat (4) @(negedge mclk);
      chk_pin("star clock enable", 64'h1, 64'(sync_clk_oe_n));
      wr(`SCM_OFS_FINE_EN, 64'h1);
      // star sync active at the write: resolved by standard rules despite fine enable
      std_req(64'h75bcd15);
      star_sync_pin = 1'b0;
      repeat (4) @(negedge mclk);
      chk_pin("pending reads", 64'h0, 64'(exp_q.size()));
      tally_and_finish();
   end
endmodule : sample_clock_mode_control_tb
